/* File: rtl/scr_consts.vh */
// constants for the system configuration and cpu control register group
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH

// register byte addresses (processor memory space)
`define SCR_ADDR_SYS_CACHE  32'hFEF88000
`define SCR_ADDR_CPU0_CACHE 32'hFEF88100
`define SCR_ADDR_CPU1_CACHE 32'hFEF88200
`define SCR_ADDR_CPU_CTRL   32'hFEF88300
`define SCR_ADDR_MEM_CFG    32'hFEF80404

// memory configuration fields (lsb-0 positions within the 32-bit word)
`define SCR_L2R_LSB   8
`define SCR_L2R_MSB   11
`define SCR_FLS_LSB   3
`define SCR_FLS_MSB   5

// l2 clock ratio codes
`define SCR_L2R_OFF   4'h0
`define SCR_L2R_MAX   4'h5

// flash size code for no flash fitted
`define SCR_FLS_NONE  3'h7

// cpu control bit positions, register bit 0 is the msb of the byte
`define SCR_CC_B0     7
`define SCR_CC_LE     6
`define SCR_CC_B2     5
`define SCR_CC_TB     4

// cpu control reset value of the timebase enable
`define SCR_TB_RST    1'h1

// value returned for unimplemented locations and undefined bits
`define SCR_UNDEF     32'h00000000

`endif

/* File: rtl/scr_regs.v */
// system configuration and cpu control register group
`timescale 1ns/1ps
`include "scr_consts.vh"

module scr_regs (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // processor register access
  input wire i_sel,
  input wire i_wr,
  input wire [31:0] i_addr,
  input wire [63:0] i_wdata,
  // strapped data pins
  input wire [31:0] i_strap,
  // register read data
  output reg [63:0] o_rdata,
  output reg o_ack,
  // processor side outputs
  output reg o_timebase_enable_pin,
  output reg [3:0] o_l2_clock_ratio,
  output reg o_l2_ratio_valid,
  output reg [2:0] o_flash_bank_size_code,
  output reg o_flash_fitted
);

  ////////////////////////////////////////////////////////////////////////
  // strap synchroniser and power-up capture

  reg [31:0] strap_m_q;
  reg [31:0] strap_s_q;
  reg [31:0] memory_configuration_q;
  reg [31:0] memory_configuration_d;
  reg cap_done_q;
  reg cap_done_d;

  // two-stage sync of the strap pins; only the second stage is read
  always @(posedge i_clk) begin
    strap_m_q <= i_strap;
    strap_s_q <= strap_m_q;
  end

  // take the synchronised straps once, then freeze the word
  always @* begin
    cap_done_d = cap_done_q;
    memory_configuration_d = memory_configuration_q;
    if (!cap_done_q) begin
      cap_done_d = 1'h1;
      memory_configuration_d = strap_s_q;
    end
  end

  // capture register; every reset arms one fresh capture
  always @(posedge i_clk) begin
    if (i_rst) begin
      cap_done_q <= 1'h0;
      memory_configuration_q <= 32'h00000000;
    end else begin
      cap_done_q <= cap_done_d;
      memory_configuration_q <= memory_configuration_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // one-hot codes of the mapped locations
  localparam [4:0] LOC_NONE = 5'h00;
  localparam [4:0] LOC_SYS = 5'h01;
  localparam [4:0] LOC_CPU0 = 5'h02;
  localparam [4:0] LOC_CPU1 = 5'h04;
  localparam [4:0] LOC_CC = 5'h08;
  localparam [4:0] LOC_MC = 5'h10;

  // compare word addresses; byte lane bits [1:0] are ignored
  function is_addr;
    input [31:0] a;
    input [31:0] b;
    begin
      is_addr = (a[31:2] == b[31:2]);
    end
  endfunction

  // map a byte address onto its one-hot location code
  function [4:0] loc_of;
    input [31:0] a;
    begin
      loc_of = LOC_NONE;
      if (is_addr(a, `SCR_ADDR_SYS_CACHE)) begin
        loc_of = LOC_SYS;
      end
      if (is_addr(a, `SCR_ADDR_CPU0_CACHE)) begin
        loc_of = LOC_CPU0;
      end
      if (is_addr(a, `SCR_ADDR_CPU1_CACHE)) begin
        loc_of = LOC_CPU1;
      end
      if (is_addr(a, `SCR_ADDR_CPU_CTRL)) begin
        loc_of = LOC_CC;
      end
      if (is_addr(a, `SCR_ADDR_MEM_CFG)) begin
        loc_of = LOC_MC;
      end
    end
  endfunction

  wire [4:0] loc;
  wire rd_req;
  wire wr_req;

  // location touched this cycle and the kind of access
  assign loc = loc_of(i_addr);
  assign rd_req = i_sel && !i_wr;
  assign wr_req = i_sel && i_wr;

  ////////////////////////////////////////////////////////////////////////
  // cpu control register

  reg tb_en_q;
  reg tb_en_d;
  reg [7:0] cc_byte;

  // only the timebase bit takes writes; lane 32..39 is wdata[31:24]
  // writes to the three cache locations fall through untouched
  always @* begin
    tb_en_d = tb_en_q;
    if (wr_req && (loc == LOC_CC)) begin
      tb_en_d = i_wdata[24 + `SCR_CC_TB];
    end
  end

  // timebase enable bit, set by reset so the time base runs
  always @(posedge i_clk) begin
    if (i_rst) begin
      tb_en_q <= `SCR_TB_RST;
    end else begin
      tb_en_q <= tb_en_d;
    end
  end

  // read-back byte: bit 0 high, endian select wired off, spare bits 0
  // software pairs the endian bit with the bridge on its own
  always @* begin
    cc_byte = 8'h00;
    cc_byte[`SCR_CC_B0] = 1'h1;
    cc_byte[`SCR_CC_LE] = 1'h0;
    cc_byte[`SCR_CC_B2] = 1'h0;
    cc_byte[`SCR_CC_TB] = tb_en_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // read data selection

  reg [63:0] rdata_d;

  // cache locations and misses give the undefined filler word
  always @* begin
    rdata_d = 64'h0000000000000000;
    if (rd_req) begin
      case (loc)
        LOC_SYS: begin
          rdata_d = {`SCR_UNDEF, `SCR_UNDEF};
        end
        LOC_CPU0: begin
          rdata_d = {`SCR_UNDEF, `SCR_UNDEF};
        end
        LOC_CPU1: begin
          rdata_d = {`SCR_UNDEF, `SCR_UNDEF};
        end
        LOC_CC: begin
          rdata_d = {32'h00000000, cc_byte, 24'h000000};
        end
        LOC_MC: begin
          rdata_d = {memory_configuration_q, 32'h00000000};
        end
        default: begin
          rdata_d = {`SCR_UNDEF, `SCR_UNDEF};
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration field decode

  wire [3:0] l2r;
  wire [2:0] fls;
  reg l2_valid_d;
  reg flash_fitted_d;

  // fields of the frozen configuration word
  assign l2r = memory_configuration_q[`SCR_L2R_MSB:`SCR_L2R_LSB];
  assign fls = memory_configuration_q[`SCR_FLS_MSB:`SCR_FLS_LSB];

  // ratio codes above the last ratio are reserved, zero is off
  always @* begin
    l2_valid_d = (l2r != `SCR_L2R_OFF) && (l2r <= `SCR_L2R_MAX);
    flash_fitted_d = (fls != `SCR_FLS_NONE);
  end

  ////////////////////////////////////////////////////////////////////////
  // output registers

  // bus answer, one cycle after each request
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_ack <= 1'h0;
      o_rdata <= 64'h0000000000000000;
    end else begin
      o_ack <= i_sel;
      o_rdata <= rdata_d;
    end
  end

  // time base enable pin follows the bit one cycle later, held low during reset
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_timebase_enable_pin <= 1'h0;
    end else begin
      o_timebase_enable_pin <= tb_en_q;
    end
  end

  // decoded configuration outputs
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_l2_clock_ratio <= 4'h0;
      o_l2_ratio_valid <= 1'h0;
      o_flash_bank_size_code <= 3'h0;
      o_flash_fitted <= 1'h0;
    end else begin
      o_l2_clock_ratio <= l2r;
      o_l2_ratio_valid <= l2_valid_d;
      o_flash_bank_size_code <= fls;
      o_flash_fitted <= flash_fitted_d;
    end
  end

endmodule // scr_regs

/* File: bench/scr_regs_asserts.sv */
// checker for the cpu control and configuration register group
`timescale 1ns/1ps
module scr_chk(input wire i_clk,i_rst,i_sel,i_wr,o_ack,o_timebase_enable_pin,
  o_l2_ratio_valid,o_flash_fitted,input wire [31:0] i_addr,
  input wire [63:0] i_wdata,o_rdata,input wire [3:0] o_l2_clock_ratio,
  input wire [2:0] o_flash_bank_size_code);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // decoded accesses
  wire cc=i_sel&&i_addr==32'hFEF88300;
  wire cw=cc&&i_wr;
  wire mr=i_sel&&!i_wr&&i_addr==32'hFEF80404;
  ack_pulse_a: assert property(i_sel|=>o_ack) else $error("ack");
  ack_idle_a: assert property(!i_sel|=>!o_ack&&o_rdata==0) else $error("i");
  cc_read_a: assert property(cc&&!i_wr|=>o_rdata[31:24]==
    {1'b1,2'b0,o_timebase_enable_pin,4'h0}) else $error("cc");
  tb_write_a: assert property(cw|=>##1 o_timebase_enable_pin==
    $past(i_wdata[28],2)) else $error("tb");
  tb_hold_a: assert property($changed(o_timebase_enable_pin)|->
    $past(cw,2)||$past(i_rst,2)) else $error("th");
  l2_valid_a: assert property(o_l2_ratio_valid==
    (o_l2_clock_ratio inside {[1:5]})) else $error("l2");
  flash_fit_a: assert property(!$past(i_rst,3)|->o_flash_fitted==
    (o_flash_bank_size_code!=3'h7)) else $error("fl");
  cfg_hold_a: assert property(!$past(i_rst,3)|->$stable(o_l2_clock_ratio)
    &&$stable(o_flash_bank_size_code)) else $error("ro");
  cfg_read_a: assert property(mr|=>o_rdata[43:40]==o_l2_clock_ratio&&
    o_rdata[37:35]==o_flash_bank_size_code) else $error("mr");
  cover property(cw);
  cover property(mr);
  cover property($fell(o_timebase_enable_pin));
endmodule // scr_chk
bind scr_regs scr_chk u_chk(.*);

/* File: bench/tb_system_config_control_regs.sv */
// self-checking bench for the register group
`timescale 1ns/1ps
module tb_system_config_control_regs;
  reg i_clk=0,i_rst=1,i_sel=0,i_wr=0;
  reg [31:0] i_addr=0,i_strap=0,s;
  reg [63:0] i_wdata=0,e;
  wire [63:0] o_rdata;
  wire o_ack,o_timebase_enable_pin,o_l2_ratio_valid,o_flash_fitted;
  wire [3:0] o_l2_clock_ratio;
  wire [2:0] o_flash_bank_size_code;
  int mismatches=0,n_compared=0,tb,k,a;
  scr_regs dut_u(.*);
  task chk(input [63:0] v,x,input string n);
    n_compared++;
    if (v!==x) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h",n,x,v);
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d",n_compared,mismatches);
    if (mismatches==0&&n_compared>0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #2.5 i_clk=~i_clk;
  // two power-up passes with random straps, each followed by 40 random accesses
  initial begin
    k=$urandom(32'hae73c5ba);
    repeat (2) begin
      s=$urandom;
      i_strap=s;
      i_rst=1;
      tb=1;
      repeat (6) @(posedge i_clk);
      #1 i_rst=0;
      repeat (3) @(posedge i_clk);
      #1 i_strap=$urandom;
      repeat (40) begin
        a=$urandom%6;
        i_addr=a<4?32'hFEF88000+a*256:a==4?32'hFEF80404:32'hFEF88400;
        i_wr=$urandom;
        i_wdata={$urandom,$urandom};
        i_sel=1;
        e=i_wr?0:a==3?{32'h0,1'b1,2'b0,tb[0],28'h0}:a==4?{s,32'h0}:0;
        @(posedge i_clk);
        #1 i_sel=0;
        if (i_wr&&a==3) tb=i_wdata[28];
        chk(o_ack,1,"ack");
        if (i_wr||a>2) chk(o_rdata,e,"rdata");
        @(posedge i_clk);
        #1 chk(o_timebase_enable_pin,tb,"pin");
      end
      chk(o_l2_clock_ratio,s[11:8],"l2");
      chk(o_l2_ratio_valid,s[11:8]>0&&s[11:8]<6,"l2v");
      chk(o_flash_bank_size_code,s[5:3],"fls");
      chk(o_flash_fitted,s[5:3]!=7,"fit");
    end
    final_report;
  end
endmodule // tb_system_config_control_regs
